// >>> include/aau_regs.vh
// register selectors, field layout and reset values of the address unit
`ifndef AAU_REGS_VH
`define AAU_REGS_VH
// register selector codes on the x data bus port
`define AAU_SEL_PTR0      4'h0
`define AAU_SEL_PTR5      4'h5
`define AAU_SEL_CFG_I     4'h6
`define AAU_SEL_CFG_J     4'h7
`define AAU_SEL_STACK     4'h8
`define AAU_SEL_BASE      4'h9
`define AAU_SEL_MINMAX    4'ha
// configuration register fields
`define AAU_MOD_MSB       15
`define AAU_MOD_LSB       7
`define AAU_STEP_MSB      6
`define AAU_STEP_LSB      0
// post-modify kinds
`define AAU_MOD_NONE      2'h0
`define AAU_MOD_INC       2'h1
`define AAU_MOD_DEC       2'h2
`define AAU_MOD_STEP      2'h3
// address source codes for a single-register access
`define AAU_SRC_STACK     3'h6
`define AAU_SRC_BASE      3'h7
// reset value and unit increment
`define AAU_RST_WORD      16'h0000
`define AAU_ONE           16'h0001
// alternate bank slot codes
`define AAU_BANK_P0       2'h0
`define AAU_BANK_P1       2'h1
`define AAU_BANK_P4       2'h2
`define AAU_BANK_CFG      2'h3
`endif

// >>> hw/aau_address_arith_unit.v
// data address arithmetic unit: pointers, configs, modifiers, x bus access
`include "aau_regs.vh"

module aau_address_arith_unit #(
    parameter DW = 16                  // address and data width
) (
    // clock and reset
    input  wire          sys_clk,
    input  wire          rst,
    // x data bus register access
    input  wire          xdb_wr,
    input  wire [3:0]    xdb_sel,
    input  wire [DW-1:0] x_data_bus_in,
    output reg  [DW-1:0] x_data_bus_out,
    // x side address request (pointer 0-5, or single-register source)
    input  wire          xa_req,
    input  wire          xa_single,
    input  wire [2:0]    xa_src,
    input  wire [1:0]    xa_mod,
    input  wire          xa_index,
    input  wire [DW-1:0] xa_offset,
    // y/program side request (pointer 4-5)
    input  wire          ya_req,
    input  wire          ya_sel,
    input  wire [1:0]    ya_mod,
    // pointer modify instruction and minmax latch
    input  wire          pointer_modify_instr,
    input  wire          minmax_op,
    // stack pointer modify
    input  wire          stack_push,
    input  wire          stack_pop,
    // alternate bank exchange
    input  wire          bank_swap,
    input  wire [1:0]    bank_slot,
    // modulo enable bits from status word two
    input  wire [5:0]    modulo_enable_bits,
    // addresses and flag out
    output reg  [DW-1:0] x_address_bus,
    output reg  [DW-1:0] y_address_bus,
    output reg           pointer_zero_flag
);

    // pointer file and control registers
    reg [DW-1:0] pointer_regs [0:5];            // primary pointers
    reg [DW-1:0] config_i_reg, config_j_reg;
    reg [DW-1:0] index_base_reg, stack_pointer_reg, minmax_latch_reg;
    reg [DW-1:0] alt_pointer_zero_reg, alt_pointer_one_reg;
    reg [DW-1:0] alt_pointer_four_reg, alt_config_i_reg;

    integer k;

    // post-modify one pointer value; plain 16-bit adds wrap by nature
    function [DW-1:0] post_mod;
        input [DW-1:0] val;
        input [1:0]    kind;
        input [DW-1:0] cfg;
        input          modulo_on;
        reg   [DW-1:0] delta;
        reg   [DW-1:0] lin;
        reg   [8:0]    modv;
        reg   [8:0]    low9;
        begin
            case (kind)
                `AAU_MOD_INC:  delta = `AAU_ONE;
                `AAU_MOD_DEC:  delta = ~`AAU_RST_WORD;
                `AAU_MOD_STEP: delta = {{(DW-7){cfg[`AAU_STEP_MSB]}},
                                        cfg[`AAU_STEP_MSB:`AAU_STEP_LSB]};
                default:       delta = `AAU_RST_WORD;
            endcase
            lin  = val + delta;
            modv = cfg[`AAU_MOD_MSB:`AAU_MOD_LSB];
            low9 = val[8:0];
            // modulo: wrap within the 0..modv window of the low bits
            if (modulo_on && kind != `AAU_MOD_NONE) begin
                if (!delta[DW-1] && low9 == modv)
                    post_mod = {val[DW-1:9], 9'h000};
                else if (delta[DW-1] && low9 == 9'h000)
                    post_mod = {val[DW-1:9], modv};
                else
                    post_mod = {val[DW-1:9], lin[8:0]};
            end else begin
                post_mod = lin;
            end
        end
    endfunction

    // combinational address selection; no extra cycle taken
    reg [DW-1:0] xa_val, xa_cfg, xa_new, ya_val, ya_new, xa_addr;
    reg          xa_modon;
    always @* begin
        if (xa_single && xa_src == `AAU_SRC_STACK)
            xa_val = stack_pointer_reg;
        else if (xa_single && xa_src == `AAU_SRC_BASE)
            xa_val = index_base_reg;
        else if (xa_single || xa_src[2])
            xa_val = pointer_regs[xa_src[2:0] > 3'h5 ? 3'h5 : xa_src];
        else
            xa_val = pointer_regs[{1'b0, xa_src[1:0]}];
        // sources 4-5 pair with config j, all others config i
        xa_cfg   = (xa_src == 3'h4 || xa_src == 3'h5) ? config_j_reg
                                                      : config_i_reg;
        xa_modon = (xa_src <= 3'h5) ? modulo_enable_bits[xa_src] : 1'b0;
        xa_new   = post_mod(xa_val, xa_mod, xa_cfg, xa_modon);
        xa_addr  = xa_index ? index_base_reg + xa_offset : xa_val;
        ya_val   = pointer_regs[ya_sel ? 3'h5 : 3'h4];
        ya_new   = post_mod(ya_val, ya_mod, config_j_reg,
                            modulo_enable_bits[ya_sel ? 3'h5 : 3'h4]);
    end

    // register updates: bus writes, post-modify, swaps, latch
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (k = 0; k < 6; k = k + 1)
                pointer_regs[k] <= `AAU_RST_WORD;
            config_i_reg         <= `AAU_RST_WORD;
            config_j_reg         <= `AAU_RST_WORD;
            index_base_reg       <= `AAU_RST_WORD;
            stack_pointer_reg    <= `AAU_RST_WORD;
            minmax_latch_reg     <= `AAU_RST_WORD;
            alt_pointer_zero_reg <= `AAU_RST_WORD;
            alt_pointer_one_reg  <= `AAU_RST_WORD;
            alt_pointer_four_reg <= `AAU_RST_WORD;
            alt_config_i_reg     <= `AAU_RST_WORD;
            x_address_bus        <= `AAU_RST_WORD;
            y_address_bus        <= `AAU_RST_WORD;
            x_data_bus_out       <= `AAU_RST_WORD;
            pointer_zero_flag    <= 1'b0;
        end else begin
            // addresses presented before modification (post-modify)
            if (xa_req)
                x_address_bus <= xa_addr;
            if (ya_req)
                y_address_bus <= ya_val;
            // x side post-modify of the chosen source
            if (xa_req && !xa_index) begin
                if (xa_single && xa_src == `AAU_SRC_STACK)
                    stack_pointer_reg <= xa_new;
                else if (xa_single && xa_src == `AAU_SRC_BASE)
                    index_base_reg <= xa_new;
                else if (xa_src <= 3'h5)
                    pointer_regs[xa_src] <= xa_new;
                // loop counting: flag shows modified pointer reached zero
                if (pointer_modify_instr)
                    pointer_zero_flag <= (xa_new == `AAU_RST_WORD);
                if (minmax_op)
                    minmax_latch_reg <= xa_val;
            end
            if (ya_req)
                pointer_regs[ya_sel ? 3'h5 : 3'h4] <= ya_new;
            // stack pointer push predecrements, pop postincrements
            if (stack_push)
                stack_pointer_reg <= stack_pointer_reg - `AAU_ONE;
            else if (stack_pop)
                stack_pointer_reg <= stack_pointer_reg + `AAU_ONE;
            // individual exchange with the alternate bank
            if (bank_swap) begin
                if (bank_slot == `AAU_BANK_P0) begin
                    pointer_regs[0]      <= alt_pointer_zero_reg;
                    alt_pointer_zero_reg <= pointer_regs[0];
                end else if (bank_slot == `AAU_BANK_P1) begin
                    pointer_regs[1]     <= alt_pointer_one_reg;
                    alt_pointer_one_reg <= pointer_regs[1];
                end else if (bank_slot == `AAU_BANK_P4) begin
                    pointer_regs[4]      <= alt_pointer_four_reg;
                    alt_pointer_four_reg <= pointer_regs[4];
                end else begin
                    config_i_reg     <= alt_config_i_reg;
                    alt_config_i_reg <= config_i_reg;
                end
            end
            // bus writes come last so they win over modification
            if (xdb_wr) begin
                if (xdb_sel <= `AAU_SEL_PTR5)
                    pointer_regs[xdb_sel[2:0]] <= x_data_bus_in;
                else if (xdb_sel == `AAU_SEL_CFG_I)
                    config_i_reg <= x_data_bus_in;
                else if (xdb_sel == `AAU_SEL_CFG_J)
                    config_j_reg <= x_data_bus_in;
                else if (xdb_sel == `AAU_SEL_STACK)
                    stack_pointer_reg <= x_data_bus_in;
                else if (xdb_sel == `AAU_SEL_BASE)
                    index_base_reg <= x_data_bus_in;
                else if (xdb_sel == `AAU_SEL_MINMAX)
                    minmax_latch_reg <= x_data_bus_in;
            end
            // registered read data; unmapped selectors read zero
            if (xdb_sel <= `AAU_SEL_PTR5)
                x_data_bus_out <= pointer_regs[xdb_sel[2:0]];
            else if (xdb_sel == `AAU_SEL_CFG_I)
                x_data_bus_out <= config_i_reg;
            else if (xdb_sel == `AAU_SEL_CFG_J)
                x_data_bus_out <= config_j_reg;
            else if (xdb_sel == `AAU_SEL_STACK)
                x_data_bus_out <= stack_pointer_reg;
            else if (xdb_sel == `AAU_SEL_BASE)
                x_data_bus_out <= index_base_reg;
            else if (xdb_sel == `AAU_SEL_MINMAX)
                x_data_bus_out <= minmax_latch_reg;
            else
                x_data_bus_out <= `AAU_RST_WORD;
        end
    end

endmodule

// >>> bench/aau_mem_model.sv
// partner: core data memory answering on the x address bus
module aau_mem_model (
    // clock
    input  wire logic        sys_clk,
    // address from the unit, read word back to the core
    input  wire logic [15:0] x_address_bus,
    output logic      [15:0] x_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // one flat space, so only the address picks the word
    always @(posedge sys_clk) x_rd <= {x_address_bus[7:0], ~x_address_bus[15:8]};
endmodule

// >>> bench/aau_address_arith_unit_sva.sv
// checker: port-level properties of the address arithmetic unit
module aau_unit_sva #(parameter DW = 16) (
    input wire logic sys_clk, rst, xdb_wr, xa_req, xa_index, ya_req, ya_sel,
    input wire logic pointer_modify_instr, minmax_op, stack_push, stack_pop,
    input wire logic bank_swap, pointer_zero_flag, xa_single,
    input wire logic [3:0] xdb_sel,
    input wire logic [2:0] xa_src,
    input wire logic [1:0] xa_mod, ya_mod,
    input wire logic [5:0] modulo_enable_bits,
    input wire logic [DW-1:0] x_data_bus_in, x_data_bus_out, xa_offset,
    input wire logic [DW-1:0] x_address_bus, y_address_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // nothing of higher priority touches a pointer this cycle
    wire calm = !xdb_wr && !bank_swap && !stack_push && !stack_pop && !ya_req;
    // linear delta: none, +1 or -1
    function automatic logic [DW-1:0] dl(input logic [1:0] m);
        return m == 2'h1 ? DW'(1) : (m == 2'h2 ? '1 : '0);
    endfunction
    sequence x_lin_s;
        xa_req && !xa_index && xa_mod != 2'h3 && xa_src < 3'h6 && calm
            && !modulo_enable_bits[xa_src];
    endsequence
    x_linear_a: assert property (
        x_lin_s ##1 (xa_req && !xa_index && xa_src == $past(xa_src))
        |=> x_address_bus == $past(x_address_bus) + dl($past(xa_mod, 2)))
        else $error("x post-modify wrong");
    zero_flag_a: assert property ((x_lin_s and pointer_modify_instr) |=>
        pointer_zero_flag == (x_address_bus + dl($past(xa_mod)) == '0))
        else $error("pointer zero flag wrong");
    y_linear_a: assert property (
        ya_req && ya_mod != 2'h3 && !modulo_enable_bits[3'h4 + ya_sel]
        && !xdb_wr && !bank_swap ##1 (ya_req && ya_sel == $past(ya_sel))
        |=> y_address_bus == $past(y_address_bus) + dl($past(ya_mod, 2)))
        else $error("y post-modify wrong");
    minmax_a: assert property (
        xa_req && minmax_op && !xa_index && xa_src < 3'h6 && !xdb_wr ##1
        (!xdb_wr && xdb_sel == 4'ha && !(xa_req && minmax_op))
        |=> x_data_bus_out == $past(x_address_bus))
        else $error("minmax latch wrong");
    unmapped_a: assert property (xdb_sel > 4'ha |=> x_data_bus_out == '0)
        else $error("unmapped read not zero");
    write_read_a: assert property (
        xdb_wr && xdb_sel < 4'hb ##1 xdb_sel == $past(xdb_sel)
        |=> x_data_bus_out == $past(x_data_bus_in, 2))
        else $error("register readback wrong");
    index_a: assert property (
        !xdb_wr && !xa_req && xdb_sel == 4'h9 ##1 (xa_req && xa_index)
        |=> x_address_bus == $past(x_data_bus_out) + $past(xa_offset))
        else $error("index address wrong");
    stack_a: assert property (
        xa_req && xa_single && xa_src == 3'h6 && xa_mod == 2'h0
        && !xa_index && !xdb_wr && !stack_push && !stack_pop
        ##1 (stack_push && !stack_pop && !xdb_wr)
        ##1 (xa_req && xa_single && xa_src == 3'h6 && !xa_index)
        |=> x_address_bus == $past(x_address_bus, 2) - DW'(1))
        else $error("stack push wrong");
    cover property (xa_req && ya_req);
    cover property (xa_req && xa_index);
    cover property (bank_swap);
    cover property (xa_req && modulo_enable_bits != 6'h00);
endmodule
bind aau_address_arith_unit aau_unit_sva #(.DW(DW)) u_sva (.*);

// >>> bench/aau_address_arith_unit_tb.sv
// testbench: address arithmetic unit against its partner memory
`include "aau_regs.vh"
module aau_address_arith_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, xdb_wr = 0, xa_req = 0, xa_single = 1;
    logic xa_index = 0, ya_req = 0, ya_sel = 0, pointer_modify_instr = 0;
    logic minmax_op = 0, stack_push = 0, stack_pop = 0, bank_swap = 0;
    logic [3:0] xdb_sel = 0;
    logic [2:0] xa_src = 0;
    logic [1:0] xa_mod = 0, ya_mod = 0, bank_slot = 0, m;
    logic [5:0] modulo_enable_bits = 0;
    logic [15:0] x_data_bus_in = 0, xa_offset = 0, x_data_bus_out, x_rd;
    logic [15:0] x_address_bus, y_address_bus, v, w, r, shadow [11];
    logic pointer_zero_flag;
    int bad_count = 0, tests_run = 0, cycles = 0, p, q;
    always #5 sys_clk = ~sys_clk;
    aau_address_arith_unit dut (.*);
    aau_mem_model partner (.sys_clk, .x_address_bus, .x_rd);
    // expected linear result: +1, -1 or unchanged (a step kind is returned unchanged)
    function automatic logic [15:0] lin(logic [15:0] a, logic [1:0] k);
        return k == 2'h1 ? a + 16'h1 : (k == 2'h2 ? a - 16'h1 : a);
    endfunction
    task test_done;
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one cycle: strobes set once, then wait past the edge
    task cyc(input logic wv, xv, yv);
        xdb_wr = wv; xa_req = xv; ya_req = yv;
        @(posedge sys_clk); #1;
    endtask
    task wr(input logic [3:0] s, input logic [15:0] d);
        xdb_sel = s; x_data_bus_in = d; cyc(1, 0, 0);
    endtask
    task rd(input logic [3:0] s);
        xdb_sel = s; cyc(0, 0, 0); r = x_data_bus_out;
    endtask
    // a hang ends the run as a failure
    always @(posedge sys_clk) if (++cycles > 5000) begin
        bad_count++;
        test_done;
    end
    initial begin
        v = $urandom(59);
        repeat (5) @(posedge sys_clk);
        #1 rst = 0;
        for (int i = 0; i < 11; i++) begin rd(i[3:0]); chk(r, 16'h0); end
        for (int i = 0; i < 11; i++) begin
            shadow[i] = (i % 2) ? x_rd : 16'($urandom);
            wr(i[3:0], shadow[i]);
        end
        for (int i = 0; i < 11; i++) begin rd(i[3:0]); chk(r, shadow[i]); end
        wr(4'hc, 16'h1234); rd(4'hc); chk(r, 16'h0);
        $display("test registers done");
        for (int n = 0; n < 40; n++) begin
            p = $urandom_range(0, 5); m = n < 2 ? n + 1 : $urandom_range(0, 2);
            v = n == 0 ? 16'hffff : (n == 1 ? 16'h0001 : 16'($urandom));
            wr(p[3:0], v); xa_src = p[2:0]; xa_mod = m; pointer_modify_instr = 1;
            cyc(0, 1, 0); chk(x_address_bus, v);
            chk({15'h0, pointer_zero_flag}, {15'h0, lin(v, m) == 16'h0});
            pointer_modify_instr = 0; xa_mod = 0; cyc(0, 1, 0);
            chk(x_address_bus, lin(v, m));
        end
        for (int n = 0; n < 8; n++) begin
            p = $urandom_range(0, 3); q = $urandom_range(0, 1);
            v = $urandom; w = $urandom; wr(p[3:0], v); wr(4'(4 + q), w);
            xa_single = 0; xa_src = p[2:0]; xa_mod = 1; ya_sel = q[0]; ya_mod = 2;
            cyc(0, 1, 1); chk(x_address_bus, v); chk(y_address_bus, w);
            xa_mod = 0; ya_mod = 0; cyc(0, 1, 1);
            chk(x_address_bus, v + 16'h1); chk(y_address_bus, w - 16'h1);
        end
        $display("test linear done");
        wr(`AAU_SEL_CFG_I, 16'h03fe); wr(1, 16'h000a); xa_single = 1; xa_src = 1;
        xa_mod = 3; cyc(0, 1, 0); xa_mod = 0; cyc(0, 1, 0);
        chk(x_address_bus, 16'h0008);
        // low nine bits wrap at the modulo value, upper bits stay put
        modulo_enable_bits = 6'h01; wr(0, 16'h0207); xa_src = 0;
        xa_mod = 1; cyc(0, 1, 0); xa_mod = 0; cyc(0, 1, 0);
        chk(x_address_bus, 16'h0200);
        xa_mod = 2; cyc(0, 1, 0); xa_mod = 0; cyc(0, 1, 0);
        chk(x_address_bus, 16'h0207);
        modulo_enable_bits = 0; $display("test modulo done");
        wr(`AAU_SEL_STACK, 16'h0100); xa_src = `AAU_SRC_STACK; cyc(0, 1, 0);
        stack_push = 1; cyc(0, 0, 0); stack_push = 0; cyc(0, 1, 0);
        chk(x_address_bus, 16'h00ff);
        stack_pop = 1; cyc(0, 0, 0); stack_pop = 0; rd(`AAU_SEL_STACK);
        chk(r, 16'h0100);
        v = $urandom; w = $urandom; wr(`AAU_SEL_BASE, v); rd(`AAU_SEL_BASE);
        xa_index = 1; xa_offset = w; xa_src = 0; xa_mod = 1; cyc(0, 1, 0);
        chk(x_address_bus, v + w);
        xa_index = 0; rd(0); chk(r, 16'h0207);
        // index base as a single-register source, post-decremented
        xa_src = `AAU_SRC_BASE; xa_mod = 2; cyc(0, 1, 0);
        chk(x_address_bus, v);
        rd(`AAU_SEL_BASE); chk(r, v - 16'h1);
        wr(2, v); xa_src = 2; minmax_op = 1; cyc(0, 1, 0); minmax_op = 0;
        rd(`AAU_SEL_MINMAX); chk(r, v);
        for (int s = 0; s < 4; s++) begin
            p = s == 2 ? 4 : (s == 3 ? 6 : s); v = $urandom; wr(p[3:0], v);
            bank_slot = s[1:0]; bank_swap = 1; cyc(0, 0, 0); bank_swap = 0;
            rd(p[3:0]); chk(r, 16'h0);
            bank_swap = 1; cyc(0, 0, 0); bank_swap = 0; rd(p[3:0]); chk(r, v);
        end
        $display("test stack index bank done");
        test_done;
    end
endmodule
